/* File: nvmseq_pkg.sv */
package nvmseq_pkg;
	// register byte offsets on the apb bus
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] KEY_OFS    = 12'h004;
	localparam logic [11:0] ADDR_OFS   = 12'h008;
	localparam logic [11:0] DATA_OFS   = 12'h00C;
	localparam logic [11:0] STATUS_OFS = 12'h010;

	// control register fields
	localparam int START_BIT = 15;
	localparam int WRITE_ENABLE_BIT_BIT  = 14;
	localparam int ERR_BIT   = 13;
	localparam int ERASE_BIT = 6;
	localparam int OP_W      = 6;
	localparam logic [OP_W-1:0] OP_ROW_ERASE = 6'h18;
	localparam logic [OP_W-1:0] OP_ROW_PROG  = 6'h04;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// memory map
	localparam int ADDR_W       = 20;
	localparam int ROW_INSTR    = 32;
	localparam int ROW_ADDR_LSB = $clog2(2 * ROW_INSTR);
	localparam logic [ADDR_W-1:0] EE_TOP = 20'h7FFFF;
	localparam int EE_WORDS = 256;
	localparam int EE_W     = 16;
	localparam logic [EE_W-1:0] EE_ERASED = 16'hFFFF;

	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int ROW_ERASE_US    = 2000;
	localparam int ROW_PROG_US     = 2000;
	localparam int EE_OP_US        = 4;
	localparam int ROW_ERASE_CYC   = (ROW_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_PROG_CYC    = (ROW_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EE_OP_CYC       = (EE_OP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNLOCK_HOLD_CYC = 16;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FLASH = 3'b010,
		ST_EE    = 3'b100
	} nvmseq_state_type;
endpackage

/* File: nvmseq_unlock.sv */
`timescale 1ns/10ps
module nvmseq_unlock #(
	parameter int HOLD = nvmseq_pkg::UNLOCK_HOLD_CYC
) (
	input  wire logic       pclk,     // system clock
	input  wire logic       presetn,  // async reset, low
	input  wire logic       wr_evt,   // any completed bus write
	input  wire logic       key_wr,   // that write hit the key register
	input  wire logic [7:0] key_val,  // written key byte
	output logic            armed_q   // unlock open for the next write
);
	generate
		if (HOLD < 1) begin : g_chk
			$error("unlock hold must be at least one cycle");
		end
	endgenerate

	logic                    first_q;
	logic [$clog2(HOLD+1):0] hold_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_q <= 1'b0;
		end else if (wr_evt) begin
			first_q <= key_wr && key_val == nvmseq_pkg::KEY_FIRST; // [RL4] [RL19]
		end
	end

	// any write consumes the window, so the start bit can only ride the very next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
			hold_q  <= '0;
		end else if (wr_evt) begin
			armed_q <= first_q && key_wr && key_val == nvmseq_pkg::KEY_SECOND; // [RL4] [RL17] [RL19]
			hold_q  <= ($clog2(HOLD+1)+1)'(HOLD);
		end else if (armed_q) begin
			if (hold_q == '0) begin
				armed_q <= 1'b0; // [RL17]
			end else begin
				hold_q <= hold_q - 1'b1;
			end
		end
	end

	property p_unlock_once;
		@(posedge pclk) disable iff (!presetn)
		armed_q && wr_evt |=> !armed_q;
	endproperty
	a_unlock_once: assert property (p_unlock_once) else $error("unlock survived a write"); // [RL17]

	property p_unlock_order;
		@(posedge pclk) disable iff (!presetn)
		$rose(armed_q) |-> $past(first_q) && $past(key_val) == nvmseq_pkg::KEY_SECOND;
	endproperty
	a_unlock_order: assert property (p_unlock_order) else $error("unlock without key order"); // [RL4] [RL19]
endmodule

/* File: nvmseq_timer.sv */
`timescale 1ns/10ps
module nvmseq_timer #(
	parameter int W = 24
) (
	input  wire logic         pclk,     // system clock
	input  wire logic         presetn,  // async reset, low
	input  wire logic         start,    // load count and run
	input  wire logic [W-1:0] cycles,   // duration in clocks
	output logic              busy_q,   // counting
	output logic              done_q    // one-cycle end pulse
);
	generate
		if (W < 2) begin : g_chk
			$error("timer width too small");
		end
	endgenerate

	logic [W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				cnt_q  <= cycles;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q <= W'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end

	property p_done_after_busy;
		@(posedge pclk) disable iff (!presetn)
		done_q |-> $past(busy_q) && !busy_q;
	endproperty
	a_done_after_busy: assert property (p_done_after_busy) else $error("done without run");
endmodule

/* File: nvmseq_top.sv */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Function
// (RL1) flash erased and programmed one 32-instruction row
// (RL2) opcode 011000 plus erase and write_enable_bit: row erase
// (RL3) software loads row address before erase
// (RL4) key 55h then AAh required before start
// (RL5) start launches erase, stalls cpu, self-clears
// (RL6) software fills 32 write latches before programming
// (RL7) opcode 000100, erase clear, write_enable_bit set: row program
// (RL8) program stalls cpu, start clears when done
// (RL9) software places two no-ops after start
// (RL10) software polls start bit until zero
// (RL11) software masks interrupts five instructions around unlock
// (RL12) eeprom ends at 7FFFFh, 256 or 128 words
// (RL13) eeprom 16-bit words, each readable and writable
// (RL14) eeprom operations never stall the cpu
// (RL15) control, key and address registers drive eeprom
// (RL16) upper byte start and error, lower byte operation
// (RL17) unlock admits one following write only
// (RL18) key register write-only, guard only
// (RL19) stray write or wrong key drops unlock
// (RL20) start without write enable does nothing
module nvmseq_top #(
	parameter int EE_WORDS      = nvmseq_pkg::EE_WORDS,
	parameter int ROW_ERASE_CYC = nvmseq_pkg::ROW_ERASE_CYC,
	parameter int ROW_PROG_CYC  = nvmseq_pkg::ROW_PROG_CYC,
	parameter int EE_OP_CYC     = nvmseq_pkg::EE_OP_CYC
) (
	input  wire logic                          pclk,              // system clock
	input  wire logic                          presetn,           // async reset, low
	input  wire logic                          psel,              // apb select
	input  wire logic                          penable,           // apb access phase
	input  wire logic                          pwrite,            // apb direction
	input  wire logic [11:0]                   paddr,             // apb byte address
	input  wire logic [31:0]                   pwdata,            // apb write data
	output logic      [31:0]                   prdata_q,          // apb read data
	output logic                               pready_q,          // apb ready
	output logic                               pslverr_q,         // unmapped access
	output logic                               cpu_stall_q,       // hold the processor
	output logic                               flash_erase_q,     // row erase launch pulse
	output logic                               flash_program_q,   // row program launch pulse
	output logic [nvmseq_pkg::ADDR_W-1:0]      flash_row_addr_q   // row base address
);
	localparam int TW = 24;
	localparam int IW = $clog2(EE_WORDS);
	localparam int AW = nvmseq_pkg::ADDR_W;
	localparam logic [AW-1:0] EE_BASE = AW'(nvmseq_pkg::EE_TOP - 2 * EE_WORDS + 1);

	generate
		if (EE_WORDS != 256 && EE_WORDS != 128) begin : g_chk_ee
			$error("eeprom size must be 256 or 128 words");
		end
		if (ROW_ERASE_CYC < 1 || ROW_PROG_CYC < 1 || EE_OP_CYC < 1) begin : g_chk_t
			$error("operation times must be at least one cycle");
		end
		if (ROW_ERASE_CYC >= 2**TW || ROW_PROG_CYC >= 2**TW || EE_OP_CYC >= 2**TW) begin : g_chk_w
			$error("operation time exceeds timer width");
		end
	endgenerate

	// apb handshake: two access cycles, effects at the edge the master sees pready
	logic access;
	logic wr_evt;
	logic rd_hit;

	assign access = psel && penable && !pready_q;
	assign wr_evt = psel && penable && pready_q && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access;
		end
	end

	// registers
	logic [nvmseq_pkg::OP_W-1:0] op_q;
	logic                        erase_q;
	logic                        write_enable_bit_q;
	logic                        start_q;
	logic                        err_q;
	logic [AW-1:0]               addr_q;
	logic [nvmseq_pkg::EE_W-1:0] data_q;
	logic [nvmseq_pkg::EE_W-1:0] ee_mem [EE_WORDS];
	nvmseq_pkg::nvmseq_state_type state_q;

	logic ctrl_wr;
	logic key_wr;
	logic addr_wr;
	logic data_wr;
	logic unmapped;

	always_comb begin
		ctrl_wr  = 1'b0;
		key_wr   = 1'b0;
		addr_wr  = 1'b0;
		data_wr  = 1'b0;
		unmapped = 1'b0;
		if (paddr == nvmseq_pkg::CTRL_OFS) begin
			ctrl_wr = wr_evt;
		end else if (paddr == nvmseq_pkg::KEY_OFS) begin
			key_wr = wr_evt;
		end else if (paddr == nvmseq_pkg::ADDR_OFS) begin
			addr_wr = wr_evt;
		end else if (paddr == nvmseq_pkg::DATA_OFS) begin
			data_wr = wr_evt;
		end else if (paddr == nvmseq_pkg::STATUS_OFS) begin
			unmapped = 1'b0;
		end else begin
			unmapped = 1'b1;
		end
	end

	// key sequence guard
	logic armed;

	nvmseq_unlock u_unlock (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_evt  (wr_evt),
		.key_wr  (key_wr),
		.key_val (pwdata[7:0]),
		.armed_q (armed)
	);

	// decode of a control write that asks to start
	logic [nvmseq_pkg::OP_W-1:0] w_op;
	logic w_erase;
	logic w_write_enable_bit;
	logic w_start;
	logic in_ee;
	logic [IW-1:0] ee_idx;
	logic idle;
	logic launch_req;
	logic is_erase;
	logic is_prog;
	logic launch_flash;
	logic launch_ee;
	logic [TW-1:0] op_cycles;

	assign w_op    = pwdata[nvmseq_pkg::OP_W-1:0];
	assign w_erase = pwdata[nvmseq_pkg::ERASE_BIT];
	assign w_write_enable_bit  = pwdata[nvmseq_pkg::WRITE_ENABLE_BIT_BIT];
	assign w_start = pwdata[nvmseq_pkg::START_BIT];
	assign idle    = state_q == nvmseq_pkg::ST_IDLE;
	assign in_ee   = addr_q >= EE_BASE; // [RL12]
	assign ee_idx  = IW'((addr_q - EE_BASE) >> 1); // [RL13]

	assign launch_req = ctrl_wr && idle && w_start && w_write_enable_bit && armed; // [RL4] [RL20]
	assign is_erase   = w_op == nvmseq_pkg::OP_ROW_ERASE && w_erase; // [RL2]
	assign is_prog    = w_op == nvmseq_pkg::OP_ROW_PROG && !w_erase; // [RL7]
	assign launch_flash = launch_req && !in_ee && (is_erase || is_prog);
	assign launch_ee    = launch_req && in_ee && (is_erase || is_prog); // [RL15]

	always_comb begin
		op_cycles = TW'(EE_OP_CYC);
		if (!in_ee) begin
			op_cycles = is_erase ? TW'(ROW_ERASE_CYC) : TW'(ROW_PROG_CYC);
		end
	end

	logic t_busy;
	logic t_done;

	nvmseq_timer #(
		.W (TW)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (launch_flash || launch_ee),
		.cycles  (op_cycles),
		.busy_q  (t_busy),
		.done_q  (t_done)
	);

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= nvmseq_pkg::ST_IDLE;
		end else begin
			case (state_q)
				nvmseq_pkg::ST_IDLE: begin
					if (launch_flash) begin
						state_q <= nvmseq_pkg::ST_FLASH;
					end else if (launch_ee) begin
						state_q <= nvmseq_pkg::ST_EE;
					end
				end
				nvmseq_pkg::ST_FLASH: begin
					if (t_done) begin
						state_q <= nvmseq_pkg::ST_IDLE;
					end
				end
				nvmseq_pkg::ST_EE: begin
					if (t_done) begin
						state_q <= nvmseq_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= nvmseq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// control register; settings are frozen while an operation runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q    <= nvmseq_pkg::CTRL_RESET[nvmseq_pkg::OP_W-1:0];
			erase_q <= nvmseq_pkg::CTRL_RESET[nvmseq_pkg::ERASE_BIT];
			write_enable_bit_q  <= nvmseq_pkg::CTRL_RESET[nvmseq_pkg::WRITE_ENABLE_BIT_BIT];
		end else if (ctrl_wr && idle) begin
			op_q    <= w_op; // [RL16]
			erase_q <= w_erase;
			write_enable_bit_q  <= w_write_enable_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= nvmseq_pkg::CTRL_RESET[nvmseq_pkg::START_BIT];
		end else if (launch_flash || launch_ee) begin
			start_q <= 1'b1; // [RL5]
		end else if (t_done) begin
			start_q <= 1'b0; // [RL5] [RL8]
		end
	end

	// error flag: a bad opcode under a valid unlock; hardware set beats software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= nvmseq_pkg::CTRL_RESET[nvmseq_pkg::ERR_BIT];
		end else if (launch_req && !(is_erase || is_prog)) begin
			err_q <= 1'b1; // [RL16]
		end else if (ctrl_wr && idle && !pwdata[nvmseq_pkg::ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_stall_q <= 1'b0;
		end else if (launch_flash) begin
			cpu_stall_q <= 1'b1; // [RL5] [RL8]
		end else if (t_done) begin
			cpu_stall_q <= 1'b0; // [RL14]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_erase_q   <= 1'b0;
			flash_program_q <= 1'b0;
		end else begin
			flash_erase_q   <= launch_flash && is_erase; // [RL2]
			flash_program_q <= launch_flash && is_prog; // [RL7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_row_addr_q <= '0;
		end else if (launch_flash) begin
			flash_row_addr_q <= {addr_q[AW-1:nvmseq_pkg::ROW_ADDR_LSB], nvmseq_pkg::ROW_ADDR_LSB'(0)}; // [RL1]
		end
	end

	// address and data latches cannot move under a running operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= '0;
		end else if (addr_wr && idle) begin
			addr_q <= pwdata[AW-1:0]; // [RL15]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_q <= '0;
		end else if (data_wr && idle) begin
			data_q <= pwdata[nvmseq_pkg::EE_W-1:0];
		end
	end

	// eeprom words commit when the operation time has elapsed
	generate
		for (genvar i = 0; i < EE_WORDS; i++) begin : g_ee
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ee_mem[i] <= nvmseq_pkg::EE_ERASED;
				end else if (t_done && state_q == nvmseq_pkg::ST_EE && ee_idx == IW'(i)) begin
					ee_mem[i] <= erase_q ? nvmseq_pkg::EE_ERASED : data_q; // [RL13]
				end
			end
		end
	endgenerate

	// read path; key register reads as zero
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (paddr == nvmseq_pkg::CTRL_OFS) begin
			rd_val[nvmseq_pkg::OP_W-1:0]     = op_q;
			rd_val[nvmseq_pkg::ERASE_BIT]    = erase_q;
			rd_val[nvmseq_pkg::ERR_BIT]      = err_q;
			rd_val[nvmseq_pkg::WRITE_ENABLE_BIT_BIT]     = write_enable_bit_q;
			rd_val[nvmseq_pkg::START_BIT]    = start_q; // [RL10]
		end else if (paddr == nvmseq_pkg::ADDR_OFS) begin
			rd_val[AW-1:0] = addr_q;
		end else if (paddr == nvmseq_pkg::DATA_OFS) begin
			rd_val[nvmseq_pkg::EE_W-1:0] = in_ee ? ee_mem[ee_idx] : data_q; // [RL13]
		end else if (paddr == nvmseq_pkg::STATUS_OFS) begin
			rd_val[2:0] = state_q;
			rd_val[3]   = t_busy;
			rd_val[4]   = armed;
		end else begin
			rd_val = 32'h0000_0000; // [RL18]
		end
	end

	assign rd_hit = access && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			if (rd_hit) begin
				prdata_q <= rd_val;
			end
			pslverr_q <= access && unmapped;
		end
	end

	// checks
	property p_start_needs_key;
		@(posedge pclk) disable iff (!presetn)
		$rose(start_q) |-> $past(armed) && $past(ctrl_wr);
	endproperty
	a_start_needs_key: assert property (p_start_needs_key) else $error("start without unlock"); // [RL4] [RL19]

	property p_start_needs_write_enable_bit;
		@(posedge pclk) disable iff (!presetn)
		$rose(start_q) |-> write_enable_bit_q;
	endproperty
	a_start_needs_write_enable_bit: assert property (p_start_needs_write_enable_bit) else $error("start without write enable"); // [RL20]

	property p_erase_select;
		@(posedge pclk) disable iff (!presetn)
		flash_erase_q |-> op_q == nvmseq_pkg::OP_ROW_ERASE && erase_q && write_enable_bit_q && cpu_stall_q;
	endproperty
	a_erase_select: assert property (p_erase_select) else $error("erase with wrong setup"); // [RL2]

	property p_prog_select;
		@(posedge pclk) disable iff (!presetn)
		flash_program_q |-> op_q == nvmseq_pkg::OP_ROW_PROG && !erase_q && write_enable_bit_q && cpu_stall_q;
	endproperty
	a_prog_select: assert property (p_prog_select) else $error("program with wrong setup"); // [RL7]

	property p_row_aligned;
		@(posedge pclk) disable iff (!presetn)
		(flash_erase_q || flash_program_q) |-> flash_row_addr_q[nvmseq_pkg::ROW_ADDR_LSB-1:0] == '0;
	endproperty
	a_row_aligned: assert property (p_row_aligned) else $error("row address not aligned"); // [RL1]

	property p_stall_during_flash;
		@(posedge pclk) disable iff (!presetn)
		state_q == nvmseq_pkg::ST_FLASH |-> cpu_stall_q && start_q && (t_busy || t_done);
	endproperty
	a_stall_during_flash: assert property (p_stall_during_flash) else $error("flash run without stall"); // [RL5] [RL8]

	property p_start_self_clears;
		@(posedge pclk) disable iff (!presetn)
		t_done |=> !start_q && !cpu_stall_q && state_q == nvmseq_pkg::ST_IDLE;
	endproperty
	a_start_self_clears: assert property (p_start_self_clears) else $error("start did not clear"); // [RL5] [RL8]

	property p_ee_no_stall;
		@(posedge pclk) disable iff (!presetn)
		state_q == nvmseq_pkg::ST_EE |-> !cpu_stall_q && start_q;
	endproperty
	a_ee_no_stall: assert property (p_ee_no_stall) else $error("eeprom run stalled cpu"); // [RL14]

	property p_ee_commit;
		@(posedge pclk) disable iff (!presetn)
		t_done && state_q == nvmseq_pkg::ST_EE && !erase_q |=> ee_mem[$past(ee_idx)] == $past(data_q);
	endproperty
	a_ee_commit: assert property (p_ee_commit) else $error("eeprom word not written"); // [RL13]
endmodule

/* File: nvmseq_flash_model.sv */
`timescale 1ns/10ps
module nvmseq_flash_model (
	input  wire logic        pclk,       // system clock
	input  wire logic        presetn,    // async reset, low
	input  wire logic        erase_go,   // row erase launch pulse
	input  wire logic        prog_go,    // row program launch pulse
	input  wire logic        stall,      // processor held
	input  wire logic [19:0] row_addr,   // row base address
	output int               erase_cnt,  // row erases seen
	output int               prog_cnt,   // row programs seen
	output int               bad_cnt     // launches the array cannot accept
);
	// only launch counts are kept; cell contents are not modelled, so data faults show at the bench only
	// write latches are taken as already filled with the row's 32 instructions at each program launch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_cnt <= 0;
			prog_cnt  <= 0;
			bad_cnt   <= 0;
		end else begin
			if (erase_go)
				erase_cnt <= erase_cnt + 1;
			if (prog_go)
				prog_cnt <= prog_cnt + 1;
			// a launch must target a whole 32-instruction row, below the eeprom, with the cpu held
			if ((erase_go || prog_go) && (stall !== 1'b1 || row_addr[5:0] !== 6'h00
					|| (erase_go && prog_go) || row_addr >= 20'h7FE00))
				bad_cnt <= bad_cnt + 1;
		end
	end
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q, r;
	logic        pready_q, pslverr_q, cpu_stall_q, flash_erase_q, flash_program_q, err;
	logic [19:0] flash_row_addr_q, a;
	logic [15:0] d;
	int          fails, comparisons, ne, np, erase_cnt, prog_cnt, bad_cnt;

	nvmseq_top #(.EE_WORDS(256), .ROW_ERASE_CYC(20), .ROW_PROG_CYC(20), .EE_OP_CYC(20)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .cpu_stall_q(cpu_stall_q), .flash_erase_q(flash_erase_q),
		.flash_program_q(flash_program_q), .flash_row_addr_q(flash_row_addr_q));

	nvmseq_flash_model FM (
		.pclk(pclk), .presetn(presetn), .erase_go(flash_erase_q), .prog_go(flash_program_q),
		.stall(cpu_stall_q), .row_addr(flash_row_addr_q), .erase_cnt(erase_cnt),
		.prog_cnt(prog_cnt), .bad_cnt(bad_cnt));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task end_sim;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one idle cycle after each transfer keeps every request edge free of a second assignment
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			end_sim();
		end
		r       = prdata_q;
		err     = pslverr_q;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [19:0] row_base(input logic [19:0] x);
		return x & ~20'h0003F;
	endfunction

	function automatic logic [19:0] ee_base();
		return nvmseq_pkg::EE_TOP - 20'(2 * nvmseq_pkg::EE_WORDS) + 20'h1;
	endfunction

	task keys(input logic [7:0] k1, input logic [7:0] k2, input int mid);
		apb(1'b1, nvmseq_pkg::KEY_OFS, {24'h0, k1});
		if (mid == 1)
			apb(1'b1, nvmseq_pkg::ADDR_OFS, {12'h0, a});
		apb(1'b1, nvmseq_pkg::KEY_OFS, {24'h0, k2});
		if (mid == 2)
			apb(1'b1, nvmseq_pkg::ADDR_OFS, {12'h0, a});
		if (mid == 3)
			repeat (nvmseq_pkg::UNLOCK_HOLD_CYC + 2) @(posedge pclk);
	endtask

	task go(input logic [15:0] cfg);
		apb(1'b1, nvmseq_pkg::ADDR_OFS, {12'h0, a});
		apb(1'b1, nvmseq_pkg::CTRL_OFS, {16'h0, cfg});
		keys(8'h55, 8'hAA, 0);
		apb(1'b1, nvmseq_pkg::CTRL_OFS, {16'h0, cfg | 16'h8000});
		repeat (2) @(posedge pclk);
	endtask

	task wait_done;
		int n;
		n = 0;
		do begin
			apb(1'b0, nvmseq_pkg::CTRL_OFS, 32'h0);
			n++;
		end while (r[15] !== 1'b0 && n < 100);
		chk1(r[15], 1'b0);
		if (r[15] !== 1'b0)
			end_sim();
	endtask

	task refuse(input logic [7:0] k1, input logic [7:0] k2, input int mid, input logic [15:0] cfg);
		keys(k1, k2, mid);
		apb(1'b1, nvmseq_pkg::CTRL_OFS, {16'h0, cfg});
		chk1(cpu_stall_q, 1'b0);
		apb(1'b0, nvmseq_pkg::CTRL_OFS, 32'h0);
		chk1(r[15], 1'b0);
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		end_sim();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		fails = 0;
		comparisons = 0;
		ne = 0;
		np = 0;
		a = 20'h0;
		void'($urandom(32'h7b8310d4));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, nvmseq_pkg::CTRL_OFS, 32'h0);
		chk(r, {16'h0, nvmseq_pkg::CTRL_RESET});
		apb(1'b0, nvmseq_pkg::KEY_OFS, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		chk1(err, 1'b1);
		for (int i = 0; i < 4; i++) begin
			a = (i == 3) ? ee_base() - 20'h1 : 20'($urandom_range(0, 32'h7FDFF));
			go(i[0] ? 16'h4004 : 16'h4058);
			chk1(cpu_stall_q, 1'b1);
			chk(32'(flash_row_addr_q), 32'(row_base(a)));
			if (i[0])
				np++;
			else
				ne++;
			wait_done();
			chk1(cpu_stall_q, 1'b0);
		end
		refuse(8'h55, 8'hAA, 0, 16'h8058);
		refuse(8'hAA, 8'h55, 0, 16'hC058);
		refuse(8'h55, 8'h5A, 0, 16'hC058);
		refuse(8'h55, 8'hAA, 1, 16'hC058);
		refuse(8'h55, 8'hAA, 2, 16'hC004);
		refuse(8'h55, 8'hAA, 3, 16'hC058);
		go(16'h400F);
		apb(1'b0, nvmseq_pkg::CTRL_OFS, 32'h0);
		chk1(r[nvmseq_pkg::ERR_BIT], 1'b1);
		apb(1'b1, nvmseq_pkg::CTRL_OFS, 32'h0);
		apb(1'b0, nvmseq_pkg::CTRL_OFS, 32'h0);
		chk1(r[nvmseq_pkg::ERR_BIT], 1'b0);
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? (nvmseq_pkg::EE_TOP & ~20'h1) : ee_base() + 20'(2 * $urandom_range(0, 255));
			d = 16'($urandom);
			apb(1'b1, nvmseq_pkg::DATA_OFS, {16'h0, d});
			go(16'h4004);
			chk1(cpu_stall_q, 1'b0);
			wait_done();
			apb(1'b1, nvmseq_pkg::DATA_OFS, {16'h0, ~d});
			apb(1'b0, nvmseq_pkg::DATA_OFS, 32'h0);
			chk(r, {16'h0, d});
			go(16'h4058);
			chk1(cpu_stall_q, 1'b0);
			wait_done();
			apb(1'b0, nvmseq_pkg::DATA_OFS, 32'h0);
			chk(r, {16'h0, nvmseq_pkg::EE_ERASED});
		end
		chk(32'(erase_cnt), 32'(ne));
		chk(32'(prog_cnt), 32'(np));
		chk(32'(bad_cnt), 32'h0);
		end_sim();
	end
endmodule
